// ==== rtl/psr_consts.vh ====
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH
// ==========================================
// Clock and timebase
`define PSR_CLK_HZ          125000000
`define PSR_TICK_HZ         1000
`define PSR_TICK_DIV        (`PSR_CLK_HZ / `PSR_TICK_HZ)
`define PSR_TICK_CW         17
// ==========================================
// Times in seconds or minutes, counts in ticks
`define PSR_FLOW_NORM_S     1200
`define PSR_FLOW_OVR_S      255
`define PSR_LIMIT_S         1200
`define PSR_OFF_DLY_MAX_MIN 5'h1E
`define PSR_FLOW_NORM_TK    22'h124F80
`define PSR_FLOW_OVR_TK     22'h03E418
`define PSR_LIMIT_TK        22'h124F80
`define PSR_MIN_TK          22'h00EA60
`define PSR_TMR_W           22
// ==========================================
// Chiller mode codes
`define PSR_MODE_W          12
`define PSR_MODE_AUTO       12'h001
`define PSR_MODE_RESET      12'h088
`define PSR_MODE_STOP       12'h000
`define PSR_MODE_EXT_STOP   12'h100
`define PSR_MODE_DISP_STOP  12'h600
`define PSR_MODE_REM_STOP   12'h300
`define PSR_MODE_LOW_AMB    12'h200
`define PSR_MODE_ICE_DONE   12'h101
`define PSR_MODE_ICE_BUILD  12'h102
// ==========================================
// Register map (byte addresses)
`define PSR_REG_CTRL        4'h0
`define PSR_REG_RSEL        4'h4
`define PSR_REG_STAT        4'h8
`define PSR_REG_MODE        4'hC
// ==========================================
// Status relay selections
`define PSR_SEL_LATCH       4'h0
`define PSR_SEL_AUTO        4'h1
`define PSR_SEL_ALARM       4'h2
`define PSR_SEL_ALM_C1      4'h3
`define PSR_SEL_ALM_C2      4'h4
`define PSR_SEL_LIMIT       4'h5
`define PSR_SEL_RUN_C1      4'h6
`define PSR_SEL_RUN_C2      4'h7
`define PSR_SEL_RUN         4'h8
`define PSR_SEL_MAXCAP      4'h9
`define PSR_RSEL_RST        16'h5982
// ==========================================
// Control register reset
`define PSR_DLY_RST         5'h01
`endif

// ==== rtl/psr_timer.v ====
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_timer (
  // Clock and reset
  input  wire                   mclk,
  input  wire                   srst,
  // Timing
  input  wire                   tick,
  input  wire                   run,
  input  wire [`PSR_TMR_W-1:0]  limit,
  output wire                   done
);
  // ==========================================
  // Tick counter that restarts when run drops
  reg [`PSR_TMR_W-1:0] cnt_r;
  assign done = run && (cnt_r >= limit);
  always @(posedge mclk) begin
    if (srst || !run) begin
      cnt_r <= {`PSR_TMR_W{1'b0}};
    end else if (tick && (cnt_r < limit)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ==== rtl/psr_sync.v ====
`timescale 1ns/1ps
module psr_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         srst,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  // ==========================================
  // Two flop synchroniser
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  assign q = s2_r;
  always @(posedge mclk) begin
    if (srst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
endmodule

// ==== rtl/psr_top.v ====
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_top (
  // Clock and reset
  input  wire                   mclk,
  input  wire                   srst,
  // Wishbone slave
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [3:0]             wb_adr_i,
  input  wire [3:0]             wb_sel_i,
  input  wire [31:0]            wb_dat_i,
  output reg  [31:0]            wb_dat_o,
  output reg                    wb_ack_o,
  // Chiller state from the main controller
  input  wire [`PSR_MODE_W-1:0] chiller_mode,
  input  wire                   override_pump,
  input  wire [2:0]             diag_latch,
  input  wire [2:0]             diag_auto,
  input  wire                   diag_other,
  input  wire                   diag_low_lwt,
  input  wire                   diag_lwt_sensor,
  input  wire                   diag_contactor,
  input  wire [1:0]             comp_run,
  input  wire                   limit_active,
  input  wire                   max_cap,
  input  wire                   cur_below_70,
  // Field input
  input  wire                   flow_ok,
  // Relay and flow diagnostic outputs
  output reg                    evap_pump_relay,
  output reg  [3:0]             status_relay,
  output reg                    flow_diag
);
  // diag_latch/diag_auto bits: [0] chiller, [1] circuit 1, [2] circuit 2
  // ==========================================
  // Input synchroniser for the flow switch
  wire flow_s;
  psr_sync #(.W(1)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .d    (flow_ok),
    .q    (flow_s)
  );

  // ==========================================
  // Timebase divider
  reg [`PSR_TICK_CW-1:0] div_r;
  reg                    tick_r;
  always @(posedge mclk) begin
    if (srst) begin
      div_r  <= {`PSR_TICK_CW{1'b0}};
      tick_r <= 1'b0;
    end else if (div_r == `PSR_TICK_DIV - 1) begin
      div_r  <= {`PSR_TICK_CW{1'b0}};
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // ==========================================
  // Registers
  reg [4:0]  dly_min_r;
  reg [15:0] rsel_r;
  wire       sel_ctrl = (wb_adr_i == `PSR_REG_CTRL);
  wire       sel_rsel = (wb_adr_i == `PSR_REG_RSEL);
  wire       bus_req  = wb_cyc_i && wb_stb_i;
  wire       ack_nxt  = bus_req && !wb_ack_o;
  wire       wr_req   = bus_req && wb_we_i && wb_ack_o;
  always @(posedge mclk) begin
    if (srst) begin
      dly_min_r <= `PSR_DLY_RST;
      rsel_r    <= `PSR_RSEL_RST;
    end else if (wr_req) begin
      if (sel_ctrl && wb_sel_i[0]) begin
        if (wb_dat_i[4:0] > `PSR_OFF_DLY_MAX_MIN)
          dly_min_r <= `PSR_OFF_DLY_MAX_MIN;
        else
          dly_min_r <= wb_dat_i[4:0];
      end
      if (sel_rsel && wb_sel_i[0])
        rsel_r[7:0] <= wb_dat_i[7:0];
      if (sel_rsel && wb_sel_i[1])
        rsel_r[15:8] <= wb_dat_i[15:8];
    end
  end

  // ==========================================
  // Mode decode
  reg  is_auto;
  reg  is_stop;
  always @* begin
    is_auto = 1'b0;
    is_stop = 1'b0;
    case (chiller_mode)
      `PSR_MODE_AUTO:      is_auto = 1'b1;
      `PSR_MODE_ICE_BUILD: is_auto = 1'b1;
      `PSR_MODE_RESET:     is_stop = 1'b1;
      `PSR_MODE_STOP:      is_stop = 1'b1;
      `PSR_MODE_EXT_STOP:  is_stop = 1'b1;
      `PSR_MODE_DISP_STOP: is_stop = 1'b1;
      `PSR_MODE_REM_STOP:  is_stop = 1'b1;
      `PSR_MODE_LOW_AMB:   is_stop = 1'b1;
      `PSR_MODE_ICE_DONE:  is_stop = 1'b1;
      default:             is_stop = 1'b0;
    endcase
  end
  wire ice_done = (chiller_mode == `PSR_MODE_ICE_DONE);
  wire want_run = is_auto || override_pump;

  // ==========================================
  // Flow supervision state
  localparam FS_IDLE   = 2'h0;
  localparam FS_PROVE  = 2'h1;
  localparam FS_PROVEN = 2'h2;
  localparam FS_TRIP   = 2'h3;
  reg  [1:0] fs_r;
  reg  [1:0] fs_nxt;
  reg        ovr_r;
  wire       prove_done;
  wire       off_done;
  reg  [`PSR_TMR_W-1:0] prove_lim;
  always @* begin
    if (ovr_r)
      prove_lim = `PSR_FLOW_OVR_TK;
    else
      prove_lim = `PSR_FLOW_NORM_TK;
  end
  psr_timer u_prove (
    .mclk  (mclk),
    .srst  (srst),
    .tick  (tick_r),
    .run   (fs_r == FS_PROVE),
    .limit (prove_lim),
    .done  (prove_done)
  );
  always @* begin
    fs_nxt = fs_r;
    case (fs_r)
      FS_IDLE:   if (want_run) fs_nxt = flow_s ? FS_PROVEN : FS_PROVE;
      FS_PROVE:  begin
        if (!want_run) fs_nxt = FS_IDLE;
        else if (flow_s) fs_nxt = FS_PROVEN;
        else if (prove_done) fs_nxt = FS_TRIP;
      end
      FS_PROVEN: if (!want_run) fs_nxt = FS_IDLE;
      FS_TRIP:   begin
        if (!want_run) fs_nxt = FS_IDLE;
        else if (flow_s) fs_nxt = FS_PROVEN;
      end
      default:   fs_nxt = FS_IDLE;
    endcase
  end
  always @(posedge mclk) begin
    if (srst) begin
      fs_r  <= FS_IDLE;
      ovr_r <= 1'b0;
    end else begin
      fs_r <= fs_nxt;
      if (fs_r == FS_IDLE)
        ovr_r <= override_pump && !is_auto;
    end
  end
  wire flow_lost = (fs_r == FS_PROVEN) && !flow_s;
  wire flow_trip = (fs_r == FS_TRIP);

  // ==========================================
  // Diagnostic classification for the pump
  wire any_latch = |diag_latch;
  wire any_auto  = |diag_auto;
  wire lwt_keep  = diag_low_lwt && !diag_lwt_sensor;
  wire lwt_drop  = diag_low_lwt && diag_lwt_sensor;
  wire auto_drop = any_auto && !lwt_keep;
  wire flow_drop = flow_lost && !is_auto;
  wire hard_diag = any_latch || diag_other || auto_drop || lwt_drop || flow_drop;
  wire pump_diag = hard_diag && !diag_contactor;

  // ==========================================
  // Off delay after leaving auto
  reg  [`PSR_TMR_W-1:0] min_cnt_r;
  reg  [4:0]            min_el_r;
  reg                   was_run_r;
  wire                  off_wait = was_run_r && !want_run && !ice_done;
  always @(posedge mclk) begin
    if (srst || !off_wait) begin
      min_cnt_r <= {`PSR_TMR_W{1'b0}};
      min_el_r  <= 5'h00;
    end else if (tick_r) begin
      if (min_cnt_r == `PSR_MIN_TK - 1'b1) begin
        min_cnt_r <= {`PSR_TMR_W{1'b0}};
        if (min_el_r < dly_min_r)
          min_el_r <= min_el_r + 1'b1;
      end else begin
        min_cnt_r <= min_cnt_r + 1'b1;
      end
    end
  end
  assign off_done = (min_el_r >= dly_min_r);

  // ==========================================
  // Pump relay
  reg pump_nxt;
  always @* begin
    if (pump_diag)
      pump_nxt = 1'b0;
    else if (want_run)
      pump_nxt = !flow_trip;
    else if (is_stop && ice_done)
      pump_nxt = 1'b0;
    else
      pump_nxt = was_run_r && !off_done;
  end
  always @(posedge mclk) begin
    if (srst) begin
      evap_pump_relay <= 1'b0;
      was_run_r       <= 1'b0;
      flow_diag       <= 1'b0;
    end else begin
      evap_pump_relay <= pump_nxt;
      flow_diag       <= flow_trip || flow_lost;
      if (want_run)
        was_run_r <= 1'b1;
      else if (off_done || pump_diag || ice_done)
        was_run_r <= 1'b0;
    end
  end

  // ==========================================
  // Limit filter timer
  wire limit_ok;
  psr_timer u_limit (
    .mclk  (mclk),
    .srst  (srst),
    .tick  (tick_r),
    .run   (limit_active),
    .limit (`PSR_LIMIT_TK),
    .done  (limit_ok)
  );

  // ==========================================
  // Maximum capacity hold
  reg maxcap_r;
  reg maxcap_nxt;
  always @* begin
    if (max_cap)
      maxcap_nxt = 1'b1;
    else if (cur_below_70)
      maxcap_nxt = 1'b0;
    else
      maxcap_nxt = maxcap_r;
  end
  always @(posedge mclk) begin
    if (srst)
      maxcap_r <= 1'b0;
    else
      maxcap_r <= maxcap_nxt;
  end

  // ==========================================
  // Status selections
  wire [15:0] cond;
  assign cond[0]  = any_latch;
  assign cond[1]  = any_auto;
  assign cond[2]  = any_latch || any_auto || diag_other;
  assign cond[3]  = diag_latch[0] || diag_latch[1] || diag_auto[0] || diag_auto[1];
  assign cond[4]  = diag_latch[0] || diag_latch[2] || diag_auto[0] || diag_auto[2];
  assign cond[5]  = limit_ok;
  assign cond[6]  = comp_run[0];
  assign cond[7]  = comp_run[1];
  assign cond[8]  = |comp_run;
  assign cond[9]  = maxcap_r;
  assign cond[15:10] = 6'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_rly
      wire [3:0] code_w = rsel_r[gi*4 +: 4];
      wire       hit_w  = cond[code_w];
      always @(posedge mclk) begin
        if (srst)
          status_relay[gi] <= 1'b0;
        else
          status_relay[gi] <= hit_w;
      end
    end
  endgenerate

  // ==========================================
  // Status word
  wire [31:0] stat_word;
  assign stat_word[0]     = evap_pump_relay;
  assign stat_word[1]     = flow_diag;
  assign stat_word[2]     = flow_s;
  assign stat_word[3]     = 1'b0;
  assign stat_word[5:4]   = fs_r;
  assign stat_word[7:6]   = 2'h0;
  assign stat_word[11:8]  = status_relay;
  assign stat_word[31:12] = 20'h00000;

  // ==========================================
  // Wishbone read and acknowledge
  always @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= ack_nxt;
      case (wb_adr_i)
        `PSR_REG_CTRL: wb_dat_o <= {27'h0000000, dly_min_r};
        `PSR_REG_RSEL: wb_dat_o <= {16'h0000, rsel_r};
        `PSR_REG_STAT: wb_dat_o <= stat_word;
        `PSR_REG_MODE: wb_dat_o <= {20'h00000, chiller_mode};
        default:       wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== tb/psr_top_chk.sv ====
`timescale 1ns/1ps
`include "psr_consts.vh"
// ====
// Pump relay and bus checks
module psr_chk (
  // Clock and reset
  input wire        mclk,
  input wire        srst,
  // Inputs
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [11:0] chiller_mode,
  input wire        override_pump,
  input wire [2:0]  diag_latch,
  input wire [2:0]  diag_auto,
  input wire        diag_other,
  input wire        diag_low_lwt,
  input wire        diag_lwt_sensor,
  input wire        diag_contactor,
  // Outputs
  input wire        wb_ack_o,
  input wire        evap_pump_relay,
  input wire        flow_diag
);
  wire dg  = |{diag_latch, diag_auto, diag_other};
  wire nd  = !dg && !diag_lwt_sensor;
  wire ex  = diag_low_lwt || diag_contactor;
  wire aut = chiller_mode == `PSR_MODE_AUTO;
  wire pmp = evap_pump_relay;
  wire hld = pmp || flow_diag;
  wire lk  = diag_low_lwt && !diag_lwt_sensor && !(|diag_latch) && !diag_other;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_diag_drop: assert property (dg && !ex |-> ##1 !pmp)
    else $error("pump on with diagnostic");
  chk_sensor_drop: assert property (diag_low_lwt && diag_lwt_sensor && !diag_contactor |-> ##1 !pmp)
    else $error("pump on with sensor fault");
  chk_auto_close: assert property (aut && !$past(aut) && nd && !ex |-> ##1 pmp)
    else $error("pump not closed on auto");
  chk_auto_hold: assert property (pmp && aut && nd && !ex |=> hld)
    else $error("pump dropped in auto");
  chk_ice_open: assert property (chiller_mode == `PSR_MODE_ICE_DONE && !override_pump && !ex |-> ##1 !pmp)
    else $error("pump on after ice done");
  chk_contactor_keep: assert property (diag_contactor && pmp && aut |=> hld)
    else $error("pump dropped on contactor fault");
  chk_lowtemp_keep: assert property (lk && pmp && aut |=> hld)
    else $error("pump dropped on low temperature");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer too long");
endmodule
bind psr_top psr_chk u_psr_chk (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .chiller_mode, .override_pump,
  .diag_latch, .diag_auto, .diag_other, .diag_low_lwt, .diag_lwt_sensor, .diag_contactor,
  .wb_ack_o, .evap_pump_relay, .flow_diag);

// ==== tb/psr_plant.sv ====
`timescale 1ns/1ps
// ====
// Pump contactor with flow switch
module psr_plant (
  // Clock
  input  wire mclk,
  // Pump and flow
  input  wire pump,
  input  wire no_flow,
  output reg  flow_ok
);
  reg [3:0] sh_r = 4'h0;
  initial flow_ok = 1'b0;
  always @(posedge mclk) begin
    sh_r <= {sh_r[2:0], pump};
    flow_ok <= sh_r[3] && !no_flow;
  end
endmodule

// ==== tb/psr_top_bench.sv ====
`timescale 1ns/1ps
`include "psr_consts.vh"
// ====
// Pump and status relay bench
module psr_top_bench;
  reg         mclk, srst, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [3:0]  wb_adr_i, wb_sel_i;
  reg  [31:0] wb_dat_i, q, r;
  reg  [11:0] chiller_mode;
  reg  [2:0]  diag_latch, diag_auto;
  reg  [1:0]  comp_run;
  reg         override_pump, diag_other, diag_low_lwt, diag_lwt_sensor, diag_contactor;
  reg         limit_active, max_cap, cur_below_70, no_flow, mc;
  wire [31:0] wb_dat_o;
  wire [3:0]  status_relay;
  wire        wb_ack_o, evap_pump_relay, flow_diag, flow_ok;
  integer     seed, fail_count, cmp_count, cyc_n, i, k;
  reg  [11:0] codes [0:6] = '{`PSR_MODE_RESET, `PSR_MODE_STOP, `PSR_MODE_EXT_STOP,
    `PSR_MODE_DISP_STOP, `PSR_MODE_REM_STOP, `PSR_MODE_LOW_AMB, `PSR_MODE_ICE_DONE};
  reg  [6:0]  dv [0:5] = '{7'h01, 7'h02, 7'h04, 7'h4A, 7'h18, 7'h61};
  localparam [15:0] DEF = {`PSR_SEL_LIMIT, `PSR_SEL_MAXCAP, `PSR_SEL_RUN, `PSR_SEL_ALARM};
  psr_top u_psr_top (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .chiller_mode, .override_pump, .diag_latch, .diag_auto, .diag_other,
    .diag_low_lwt, .diag_lwt_sensor, .diag_contactor, .comp_run, .limit_active, .max_cap,
    .cur_below_70, .flow_ok, .evap_pump_relay, .status_relay, .flow_diag);
  psr_plant u_psr_plant (.mclk, .pump(evap_pump_relay), .no_flow, .flow_ok);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 30000) begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end
  task end_sim;
    begin
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge mclk);
      while (wb_ack_o !== 1'b1) @(posedge mclk);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task wt(input s, input v);
    integer n;
    begin
      n = 0;
      while ((s ? flow_diag : evap_pump_relay) !== v && n < 40) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk(s ? flow_diag : evap_pump_relay, v);
    end
  endtask
  function rx(input [3:0] c);
    case (c)
      `PSR_SEL_LATCH:  rx = |diag_latch;
      `PSR_SEL_AUTO:   rx = |diag_auto;
      `PSR_SEL_ALARM:  rx = |{diag_latch, diag_auto, diag_other};
      `PSR_SEL_ALM_C1: rx = |{diag_latch[1:0], diag_auto[1:0]};
      `PSR_SEL_ALM_C2: rx = |{diag_latch[2], diag_latch[0], diag_auto[2], diag_auto[0]};
      `PSR_SEL_RUN_C1: rx = comp_run[0];
      `PSR_SEL_RUN_C2: rx = comp_run[1];
      `PSR_SEL_RUN:    rx = |comp_run;
      `PSR_SEL_MAXCAP: rx = mc;
      default:         rx = 1'b0;
    endcase
  endfunction
  // ====
  // Random inputs, every relay compared with its selection
  task rel(input [15:0] s, input wr);
    begin
      if (wr)
        wb(1'b1, `PSR_REG_RSEL, {16'h0000, s});
      for (i = 0; i < 30; i = i + 1) begin
        @(posedge mclk);
        r = $random(seed);
        {diag_latch, diag_auto, diag_other, comp_run, limit_active, max_cap, cur_below_70} <= r[11:0];
        if (r[1])
          mc = 1'b1;
        else if (r[0])
          mc = 1'b0;
        repeat (3) @(posedge mclk);
        for (k = 0; k < 4; k = k + 1)
          chk(status_relay[k], rx(s[4*k +: 4]));
      end
      {diag_latch, diag_auto, diag_other, comp_run, limit_active} <= 10'h000;
    end
  endtask
  // ====
  // Main sequence
  initial begin
    seed = 32'h3540;
    fail_count = 0;
    cmp_count = 0;
    cyc_n = 0;
    srst = 1'b1;
    wb_sel_i = 4'hF;
    chiller_mode = `PSR_MODE_STOP;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 0;
    {override_pump, diag_latch, diag_auto, diag_other, diag_low_lwt, diag_lwt_sensor} = 0;
    {diag_contactor, comp_run, limit_active, max_cap, cur_below_70, no_flow, mc} = 0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    chk(evap_pump_relay, 1'b0);
    wb(1'b0, `PSR_REG_RSEL, 0);
    chk(q, DEF);
    rel(DEF, 1'b0);
    wb(1'b0, 4'h2, 0);
    chk(q, 0);
    wb(1'b0, `PSR_REG_CTRL, 0);
    chk(q, `PSR_DLY_RST);
    chiller_mode <= `PSR_MODE_AUTO;
    wt(1'b0, 1'b1);
    chiller_mode <= `PSR_MODE_STOP;
    repeat (200) @(posedge mclk);
    chk(evap_pump_relay, 1'b1);
    wb(1'b1, `PSR_REG_CTRL, 31);
    wb(1'b0, `PSR_REG_CTRL, 0);
    chk(q, `PSR_OFF_DLY_MAX_MIN);
    wb(1'b1, `PSR_REG_CTRL, 0);
    wt(1'b0, 1'b0);
    for (i = 0; i < 7; i = i + 1) begin
      chiller_mode <= `PSR_MODE_AUTO;
      wt(1'b0, 1'b1);
      chiller_mode <= codes[i];
      wt(1'b0, 1'b0);
    end
    override_pump <= 1'b1;
    wt(1'b0, 1'b1);
    override_pump <= 1'b0;
    wt(1'b0, 1'b0);
    chiller_mode <= `PSR_MODE_ICE_BUILD;
    wt(1'b0, 1'b1);
    chiller_mode <= `PSR_MODE_AUTO;
    wt(1'b0, 1'b1);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge mclk);
      {diag_contactor, diag_lwt_sensor, diag_low_lwt, diag_other, diag_auto[1], diag_latch[0]} <= dv[i][5:0];
      repeat (4) @(posedge mclk);
      chk(evap_pump_relay, dv[i][6]);
      {diag_contactor, diag_lwt_sensor, diag_low_lwt, diag_other, diag_auto[1], diag_latch[0]} <= 6'h00;
      wt(1'b0, 1'b1);
    end
    repeat (20) @(posedge mclk);
    no_flow <= 1'b1;
    wt(1'b1, 1'b1);
    chk(evap_pump_relay, 1'b1);
    no_flow <= 1'b0;
    wt(1'b1, 1'b0);
    chk(evap_pump_relay, 1'b1);
    rel(16'h6310, 1'b1);
    rel(16'h2874, 1'b1);
    rel(16'h0A59, 1'b1);
    end_sim;
  end
endmodule
